// ### bench/tb.sv
// Purpose: Self-checking bench for the control/status register bank
// Assumes: Shortened debounce and base divider parameters
// Notes:   Random stimulus from a fixed seed plus corner cases
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int DB = 4;  // Debounce length in data periods
  localparam int DD = 2;  // System clocks per base period
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic SCK, CS_N, SDI, SDO, SDO_OE_N;
  logic KEY_WAKE_PIN = 1'b1;
  logic WAKE_PIN = 1'b0;
  logic SUPPLY_LOW = 1'b0;
  tcs_pkg::tcs_op_mode_t OP_MODE = tcs_pkg::MODE_IDLE;
  logic [1:0] BAUD_RANGE = 2'h0;
  logic EXT_LIM = 1'b0;
  logic GENERAL_OUT_PIN, TX_BIT_TICK, RES_USE_FIXED, FRONT_END_CFG, CLK_EN_FORCE, IRQ;
  logic [4:0] POWER_SET_RESISTOR;
  int miscompares = 0;
  int n_compared = 0;
  int n;
  logic [7:0] rd, v, w;
  logic [1:0] br;
  logic ex;
  tcs_pkg::tcs_op_mode_t m;

  always #2.5 SYS_CLK = ~SYS_CLK;

  tcs_regs #(.DEBOUNCE_TICKS(DB), .DCLK_DIV(DD)) u_dut (.SYS_CLK, .RST, .SCK, .CS_N, .SDI, .SDO, .SDO_OE_N,
    .KEY_WAKE_PIN, .WAKE_PIN, .SUPPLY_LOW, .OP_MODE, .BAUD_RANGE, .EXT_LIM, .GENERAL_OUT_PIN, .TX_BIT_TICK,
    .RES_USE_FIXED, .POWER_SET_RESISTOR, .FRONT_END_CFG, .CLK_EN_FORCE, .IRQ);
  tcs_host_model u_host (.SYS_CLK, .SCK, .CS_N, .SDI, .SDO, .SDO_OE_N);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rdreg(input logic [4:0] a, output logic [7:0] d);
    u_host.xfer({tcs_pkg::CMD_READ_REG, a}, 8'h00, 1'b1, d);
  endtask
  task automatic wrreg(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] nul;
    u_host.xfer({tcs_pkg::CMD_WRITE_REG, a}, d, 1'b1, nul);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge SYS_CLK);
    #1;
  endtask
  // Bounded wait for a signal to go high
  task automatic wt(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      step(1);
      n++;
    end
  endtask
  // Expected pin level from register value and mode
  function automatic logic exp_pin(logic [7:0] r, tcs_pkg::tcs_op_mode_t md);
    return r[7] ? (md != tcs_pkg::MODE_RX) : r[6];
  endfunction
  // Expected cycles between transmit bit ticks
  function automatic int gap(logic [5:0] dv, logic [1:0] b, logic e);
    int d = (dv < 6'h0a) ? 10 : int'(dv);
    return (d + 1) * 2 * DD * (8 >> b) * (e ? 2 : 1);
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(36));
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    step(4);
    chk("pin", GENERAL_OUT_PIN, 0);
    chk("code", POWER_SET_RESISTOR, 16);
    chk("front end", FRONT_END_CFG, 1);
    // Leaving reset counts as an off-to-idle change
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("status reset", rd, 8'h04);
    rdreg(tcs_pkg::ADDR_OUT_PIN_TX_RATE, rd);
    chk("reg6", rd, 8'h14);
    rdreg(tcs_pkg::ADDR_POWER_RES_CFG, rd);
    chk("reg7", rd, 8'h50);
    rdreg(5'h08, rd);
    chk("unmapped", rd, 8'h00);
    // Random register contents in random active modes
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom;
      w = $urandom;
      if (i < 4)
        v[7:6] = i[1:0];
      w[6] = 1'b1;
      m = tcs_pkg::tcs_op_mode_t'($urandom_range(4, 1));
      @(posedge SYS_CLK) OP_MODE <= m;
      wrreg(tcs_pkg::ADDR_OUT_PIN_TX_RATE, v);
      wrreg(tcs_pkg::ADDR_POWER_RES_CFG, w);
      rdreg(tcs_pkg::ADDR_OUT_PIN_TX_RATE, rd);
      chk("reg6 rb", rd, v);
      rdreg(tcs_pkg::ADDR_POWER_RES_CFG, rd);
      chk("reg7 rb", rd, {1'b0, w[6:0]});
      chk("pin", GENERAL_OUT_PIN, exp_pin(v, m));
      chk("code", POWER_SET_RESISTOR, w[4:0]);
      chk("front end", FRONT_END_CFG, 1);
      chk("fixed", RES_USE_FIXED, m == tcs_pkg::MODE_TX && !w[5]);
    end
    // Transmit bit period: edge dividers, an invalid one, a random one
    for (int j = 0; j < 4; j++)
    begin
      v = (j == 0) ? 8'h0a : (j == 1) ? 8'h3f : (j == 2) ? 8'h03 : 8'($urandom_range(63, 10));
      br = $urandom;
      ex = $urandom;
      @(posedge SYS_CLK)
      begin
        OP_MODE <= tcs_pkg::MODE_TX;
        BAUD_RANGE <= br;
        EXT_LIM <= ex;
      end
      wrreg(tcs_pkg::ADDR_OUT_PIN_TX_RATE, v);
      wt(TX_BIT_TICK, 9000);
      step(1);
      wt(TX_BIT_TICK, 9000);
      step(1);
      wt(TX_BIT_TICK, 9000);
      chk("tick gap", n + 1, gap(v[5:0], br, ex));
    end
    // No ticks in receive or full duplex
    for (int k = 0; k < 2; k++)
    begin
      @(posedge SYS_CLK) OP_MODE <= k ? tcs_pkg::MODE_FD : tcs_pkg::MODE_RX;
      n = 0;
      repeat (5000)
      begin
        step(1);
        n += (TX_BIT_TICK === 1'b1);
      end
      chk("no ticks", n, 0);
    end
    // Wake pin rising edge
    @(posedge SYS_CLK)
    begin
      OP_MODE <= tcs_pkg::MODE_IDLE;
      WAKE_PIN <= 1'b1;
    end
    wt(IRQ, 50);
    chk("irq wake", IRQ, 1);
    chk("clk force", CLK_EN_FORCE, 1);
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("status wake", rd, 8'h02);
    chk("irq clr", IRQ, 0);
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("wake clr", rd, 8'h00);
    chk("clk free", CLK_EN_FORCE, 0);
    // Supply loss, then off to idle
    @(posedge SYS_CLK) SUPPLY_LOW <= 1'b1;
    step(10);
    @(posedge SYS_CLK) SUPPLY_LOW <= 1'b0;
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("supply", rd, 8'h04);
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("supply clr", rd, 8'h00);
    @(posedge SYS_CLK) OP_MODE <= tcs_pkg::MODE_OFF;
    step(4);
    @(posedge SYS_CLK) OP_MODE <= tcs_pkg::MODE_IDLE;
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("off idle", rd, 8'h04);
    // Bouncing key: each edge restarts a 128-cycle debounce
    @(posedge SYS_CLK)
    begin
      WAKE_PIN <= 1'b0;
      KEY_WAKE_PIN <= 1'b0;
      BAUD_RANGE <= 2'h0;
      EXT_LIM <= 1'b1;
    end
    step(60);
    @(posedge SYS_CLK) KEY_WAKE_PIN <= 1'b1;
    step(60);
    @(posedge SYS_CLK) KEY_WAKE_PIN <= 1'b0;
    step(100);
    chk("irq bounce", IRQ, 0);
    wt(IRQ, 300);
    chk("irq key", IRQ, 1);
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("key on", rd, 8'h01);
    chk("irq clr", IRQ, 0);
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("key kept", rd, 8'h01);
    // Key release, interrupt dropped by command
    @(posedge SYS_CLK) KEY_WAKE_PIN <= 1'b1;
    wt(IRQ, 300);
    chk("irq rel", IRQ, 1);
    u_host.xfer({tcs_pkg::CMD_DELETE_IRQ, 5'h00}, 8'h00, 1'b0, rd);
    chk("irq del", IRQ, 0);
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("key off", rd, 8'h00);
    // Reset in mid-run restores the defaults
    wrreg(tcs_pkg::ADDR_OUT_PIN_TX_RATE, 8'hc0);
    chk("pin sel", GENERAL_OUT_PIN, 1);
    @(posedge SYS_CLK) RST <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    step(4);
    chk("pin rst", GENERAL_OUT_PIN, 0);
    rdreg(tcs_pkg::ADDR_OUT_PIN_TX_RATE, rd);
    chk("reg6 rst", rd, 8'h14);
    rdreg(tcs_pkg::ADDR_DEVICE_STATUS, rd);
    chk("status rst", rd, 8'h04);
    test_done();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #450000;
    miscompares++;
    test_done();
  end
endmodule // tb

// ### bench/tcs_host_model.sv
// Purpose: Host controller model driving the 4-wire serial port of the register bank
// Assumes: Clock mode 0, chip select active low, MSB first
// Notes:   SCK is low for 6 system clocks and high for 7; SDI toggles while deselected
`timescale 1ns/1ps
module tcs_host_model (
  // Clock
  input wire logic SYS_CLK,
  // Serial pins
  output logic SCK,
  output logic CS_N,
  output logic SDI,
  input wire logic SDO,
  input wire logic SDO_OE_N
);
  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  initial
  begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SDI = 1'b0;
  end
  // Wait some edges; deselected data line carries no stale value
  task automatic half(input int k);
    repeat (k)
    begin
      @(posedge SYS_CLK);
      if (CS_N)
        SDI <= ~SDI;
    end
  endtask
  // One byte, MSB first; SDO read just before each rise
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge SYS_CLK);
      SCK <= 1'b0;
      SDI <= tx[i];
      half(6);
      rx[i] = SDO_OE_N ? 1'bx : SDO;
      SCK <= 1'b1;
      half(6);
    end
    @(posedge SYS_CLK);
    SCK <= 1'b0;
    half(6);
  endtask
  // Command byte, then one data byte if asked
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input bit two, output logic [7:0] rd);
    logic [7:0] nul;
    @(posedge SYS_CLK);
    CS_N <= 1'b0;
    half(6);
    shift(cmd, nul);
    if (two)
      shift(wd, rd);
    @(posedge SYS_CLK);
    CS_N <= 1'b1;
    half(8);
    #1;
  endtask
endmodule // tcs_host_model

// ### src/tcs_pkg.sv
// Purpose: Shared constants and types for the transceiver control/status register bank
// Assumes: 8-bit registers reached over the 4-wire serial command interface
// Notes:   Register addresses are the 5-bit command address field
package tcs_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_OUT_PIN_TX_RATE = 5'h06;  // Output pin source and tx rate divider
  localparam logic [4:0] ADDR_POWER_RES_CFG = 5'h07;    // Power resistor configuration
  localparam logic [4:0] ADDR_DEVICE_STATUS = 5'h10;    // Device status, read clears flags

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_PIN_TX_RATE_RESET = 8'h14;  // Pin driven by value 0, divider 20
  localparam logic [7:0] POWER_RES_CFG_RESET = 8'h50;    // Front-end bit 1, select 0, code 16

  // ----------------------------------------------------------------
  // Command types (top three bits of the command byte)
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_READ_REG = 3'h2;    // Read control/status register(s)
  localparam logic [2:0] CMD_WRITE_REG = 3'h3;   // Write control register(s)
  localparam logic [2:0] CMD_DELETE_IRQ = 3'h5;  // Drop the interrupt request

  // ----------------------------------------------------------------
  // Timing and rate constants
  // ----------------------------------------------------------------
  localparam logic [5:0] TX_DIV_MIN = 6'h0a;     // Smallest usable tx divider
  localparam logic [4:0] BASE_MULT_MAX = 5'h08;  // Multiplier for baud range 0
  localparam logic [2:0] BIT_LAST = 3'h7;        // Last bit index of a serial byte
  localparam int DEBOUNCE_PERIODS = 8195;        // Key debounce length in data clock periods
  localparam int DCLK_DIV_DEFAULT = 16;          // System clocks per base data clock period

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    MODE_OFF = 3'b000,
    MODE_IDLE = 3'b001,
    MODE_TX = 3'b010,
    MODE_RX = 3'b011,
    MODE_FD = 3'b100
  } tcs_op_mode_t;

  typedef enum logic [1:0]
  {
    SER_CMD = 2'b00,
    SER_READ = 2'b01,
    SER_WRITE = 2'b10,
    SER_IGNORE = 2'b11
  } tcs_ser_state_t;

  typedef struct packed {
    logic out_pin_source_sel;     // 1: pin shows active-low receive indicator
    logic out_pin_value;          // Pin level when source select is 0
    logic [5:0] tx_rate_divider;  // Transmit bit-rate divider
  } tcs_pin_rate_t;

  typedef struct packed {
    logic unused;                     // Reads as 0
    logic front_end_cfg_bit;          // Host keeps this at 1
    logic power_resistor_sel;         // 1: programmed code in tx and full duplex
    logic [4:0] power_resistor_code;  // Internal power-set resistor code
  } tcs_power_cfg_t;

  typedef struct packed {
    logic [4:0] zero;           // Unused, read as 0
    logic ram_supply_loss_flag; // RAM supply was too low
    logic wake_flag;            // Woken by rising edge on wake pin
    logic key_state;            // Inverse of debounced key wake pin
  } tcs_status_t;

endpackage

// ### src/tcs_regs.sv
// Purpose: Control registers 7/8 and status register of a transceiver, with serial access
// Assumes: Serial interface in clock mode 0, chip select active low, MSB first
// Notes:   All pins pass two flip-flops; one clock, slower rates are enable pulses
`timescale 1ns/1ps

module tcs_regs #(
  parameter int DEBOUNCE_TICKS = tcs_pkg::DEBOUNCE_PERIODS,
  parameter int DCLK_DIV = tcs_pkg::DCLK_DIV_DEFAULT
)(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Serial interface pins
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE_N,
  // Wake pins and supply monitor
  input wire logic KEY_WAKE_PIN,
  input wire logic WAKE_PIN,
  input wire logic SUPPLY_LOW,
  // Operating state from the mode controller
  input wire tcs_pkg::tcs_op_mode_t OP_MODE,
  input wire logic [1:0] BAUD_RANGE,
  input wire logic EXT_LIM,
  // Outputs to pin, transmitter and power amplifier
  output logic GENERAL_OUT_PIN,
  output logic TX_BIT_TICK,
  output logic RES_USE_FIXED,
  output logic [4:0] POWER_SET_RESISTOR,
  output logic FRONT_END_CFG,
  output logic CLK_EN_FORCE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_in;   // Raw asynchronous pins
  logic [NPIN-1:0] sync1_q;  // First stage, read only by second stage
  logic [NPIN-1:0] sync2_q;  // Safe synchronised levels
  logic sck_prev_q;          // Previous serial clock level
  logic key_prev_q;          // Previous key pin level
  logic wake_prev_q;         // Previous wake pin level
  tcs_pkg::tcs_op_mode_t mode_prev_q;  // Mode one cycle ago

  assign pin_in = {SUPPLY_LOW, WAKE_PIN, KEY_WAKE_PIN, SDI, CS_N, SCK};

  // Two-flop synchronisers and edge history
  always_ff @(posedge SYS_CLK)
  begin
    sync1_q <= pin_in;
    sync2_q <= sync1_q;
    sck_prev_q <= sync2_q[0];
    key_prev_q <= sync2_q[3];
    wake_prev_q <= sync2_q[4];
    mode_prev_q <= RST ? tcs_pkg::MODE_OFF : OP_MODE;
  end

  wire sck_s = sync2_q[0];
  wire cs_act = ~sync2_q[1];
  wire sdi_s = sync2_q[2];
  wire key_s = sync2_q[3];
  wire wake_s = sync2_q[4];
  wire supply_low_s = sync2_q[5];
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  tcs_pkg::tcs_pin_rate_t pin_rate_q;    // Output pin and tx rate register
  tcs_pkg::tcs_power_cfg_t power_cfg_q;  // Power resistor register
  tcs_pkg::tcs_status_t status;          // Assembled status byte
  logic key_state_q;                     // Debounced key status
  logic wake_flag_q;                     // Wake-pin flag
  logic ram_flag_q;                      // RAM supply loss flag
  logic irq_q;                           // Interrupt request

  assign status = '{zero: 5'h00, ram_supply_loss_flag: ram_flag_q, wake_flag: wake_flag_q,
                    key_state: key_state_q};

  // ----------------------------------------------------------------
  // Serial command engine
  // ----------------------------------------------------------------
  tcs_pkg::tcs_ser_state_t ser_state_q;  // Command or data phase
  logic [2:0] bit_cnt_q;                 // Bit index within current byte
  logic [6:0] shift_in_q;                // Received bits so far
  logic [7:0] shift_out_q;               // Bits on their way out
  logic [4:0] addr_q;                    // Current register address

  wire byte_done = cs_act & sck_rise & (bit_cnt_q == tcs_pkg::BIT_LAST);
  wire [7:0] rx_byte = {shift_in_q, sdi_s};
  wire in_cmd = ser_state_q == tcs_pkg::SER_CMD;
  wire cmd_read = in_cmd & (rx_byte[7:5] == tcs_pkg::CMD_READ_REG);
  wire cmd_write = in_cmd & (rx_byte[7:5] == tcs_pkg::CMD_WRITE_REG);
  wire cmd_del_irq = byte_done & in_cmd & (rx_byte[7:5] == tcs_pkg::CMD_DELETE_IRQ);
  wire load_rd = byte_done & (cmd_read | (ser_state_q == tcs_pkg::SER_READ));
  wire [4:0] ld_addr = in_cmd ? rx_byte[4:0] : 5'(addr_q + 5'h01);
  wire wr_en = byte_done & (ser_state_q == tcs_pkg::SER_WRITE);
  wire status_rd = load_rd & (ld_addr == tcs_pkg::ADDR_DEVICE_STATUS);
  wire [7:0] rd_val = (ld_addr == tcs_pkg::ADDR_OUT_PIN_TX_RATE) ? pin_rate_q :
                      (ld_addr == tcs_pkg::ADDR_POWER_RES_CFG) ? {1'b0, power_cfg_q[6:0]} :
                      (ld_addr == tcs_pkg::ADDR_DEVICE_STATUS) ? status : 8'h00;

  // Byte framing, command decode and address stepping
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || !cs_act)
    begin
      ser_state_q <= tcs_pkg::SER_CMD;
      bit_cnt_q <= 3'h0;
      shift_in_q <= 7'h00;
      shift_out_q <= 8'h00;
      addr_q <= 5'h00;
    end
    else
    begin
      if (sck_rise)
      begin
        // Sample input, MSB first
        shift_in_q <= rx_byte[6:0];
        bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
      end
      if (byte_done)
      begin
        // Next phase after a completed byte
        if (in_cmd)
          ser_state_q <= cmd_read ? tcs_pkg::SER_READ :
                         cmd_write ? tcs_pkg::SER_WRITE : tcs_pkg::SER_IGNORE;
        addr_q <= in_cmd ? rx_byte[4:0] : 5'(addr_q + 5'h01);
      end
      if (load_rd)
        shift_out_q <= rd_val;
      else if (sck_fall && bit_cnt_q != 3'h0)
        shift_out_q <= {shift_out_q[6:0], 1'b0};  // Hold MSB until first data edge
    end
  end

  // Data output pin is driven only while selected
  always_ff @(posedge SYS_CLK)
  begin
    SDO <= RST ? 1'b0 : shift_out_q[7];
    SDO_OE_N <= RST ? 1'b1 : ~cs_act;
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  // Front-end bit is stored as written; the host keeps it at 1
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pin_rate_q <= tcs_pkg::OUT_PIN_TX_RATE_RESET;
      power_cfg_q <= tcs_pkg::POWER_RES_CFG_RESET;
    end
    else if (wr_en)
    begin
      if (addr_q == tcs_pkg::ADDR_OUT_PIN_TX_RATE)
        pin_rate_q <= rx_byte;
      if (addr_q == tcs_pkg::ADDR_POWER_RES_CFG)
        power_cfg_q <= {1'b0, rx_byte[6:0]};
    end
  end

  // ----------------------------------------------------------------
  // Data clock enables
  // ----------------------------------------------------------------
  logic [15:0] dclk_cnt_q;  // Base data clock divider
  logic [4:0] mult_cnt_q;   // Range multiplier counter
  wire dclk_tick = dclk_cnt_q == 16'(DCLK_DIV - 1);
  wire [4:0] mult = 5'(tcs_pkg::BASE_MULT_MAX >> BAUD_RANGE) << EXT_LIM;
  wire xdclk_tick = dclk_tick & (mult_cnt_q == 5'(mult - 5'h01));

  // Base divider and multiplier chain
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      dclk_cnt_q <= 16'h0000;
      mult_cnt_q <= 5'h00;
    end
    else
    begin
      dclk_cnt_q <= dclk_tick ? 16'h0000 : 16'(dclk_cnt_q + 16'h0001);
      if (dclk_tick)
        mult_cnt_q <= xdclk_tick ? 5'h00 : 5'(mult_cnt_q + 5'h01);
    end
  end

  // ----------------------------------------------------------------
  // Transmit bit-rate timer
  // ----------------------------------------------------------------
  logic [6:0] tx_cnt_q;  // Data clock periods within one tx bit
  wire [5:0] div_eff = (pin_rate_q.tx_rate_divider < tcs_pkg::TX_DIV_MIN) ?
                       tcs_pkg::TX_DIV_MIN : pin_rate_q.tx_rate_divider;
  wire [6:0] tx_last = {div_eff, 1'b1};  // (divider+1)*2 - 1
  wire tx_mode = OP_MODE == tcs_pkg::MODE_TX;

  // Counts only in transmit mode
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || !tx_mode)
    begin
      tx_cnt_q <= 7'h00;
      TX_BIT_TICK <= 1'b0;
    end
    else
    begin
      TX_BIT_TICK <= xdclk_tick & (tx_cnt_q == tx_last);  // No short bit after a divider change
      if (xdclk_tick)
        tx_cnt_q <= (tx_cnt_q >= tx_last) ? 7'h00 : 7'(tx_cnt_q + 7'h01);
    end
  end

  // ----------------------------------------------------------------
  // Key input debounce
  // ----------------------------------------------------------------
  logic deb_run_q;          // Debounce counter running
  logic [15:0] deb_cnt_q;   // Data clock periods since last edge
  wire active = OP_MODE != tcs_pkg::MODE_OFF;
  wire key_edge = active & (key_s ^ key_prev_q);
  wire deb_done = deb_run_q & xdclk_tick & ~key_edge & (deb_cnt_q == 16'(DEBOUNCE_TICKS - 1));

  // Each edge outside off mode restarts the count
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      deb_run_q <= 1'b0;
      deb_cnt_q <= 16'h0000;
      key_state_q <= 1'b0;
    end
    else if (key_edge)
    begin
      deb_run_q <= 1'b1;
      deb_cnt_q <= 16'h0000;
    end
    else if (deb_run_q && xdclk_tick)
    begin
      deb_cnt_q <= 16'(deb_cnt_q + 16'h0001);
      if (deb_done)
      begin
        deb_run_q <= 1'b0;
        key_state_q <= ~key_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags and interrupt; a set always beats a read clear
  // ----------------------------------------------------------------
  wire wake_rise = wake_s & ~wake_prev_q;
  wire wake_set = wake_rise & ~wake_flag_q;
  wire off_to_idle = (mode_prev_q == tcs_pkg::MODE_OFF) && (OP_MODE == tcs_pkg::MODE_IDLE);
  wire ram_set = supply_low_s | off_to_idle;
  wire irq_set = wake_set | deb_done;

  // Sticky flags
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      wake_flag_q <= 1'b0;
      ram_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wake_rise)
        wake_flag_q <= 1'b1;
      else if (status_rd)
        wake_flag_q <= 1'b0;
      if (ram_set)
        ram_flag_q <= 1'b1;
      else if (status_rd)
        ram_flag_q <= 1'b0;
      if (irq_set)
        irq_q <= 1'b1;
      else if (status_rd || cmd_del_irq)
        irq_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      GENERAL_OUT_PIN <= 1'b0;
      RES_USE_FIXED <= 1'b0;
      POWER_SET_RESISTOR <= tcs_pkg::POWER_RES_CFG_RESET[4:0];
      FRONT_END_CFG <= tcs_pkg::POWER_RES_CFG_RESET[6];
      CLK_EN_FORCE <= 1'b0;
      IRQ <= 1'b0;
    end
    else
    begin
      GENERAL_OUT_PIN <= pin_rate_q.out_pin_source_sel ? (OP_MODE != tcs_pkg::MODE_RX)
                                                       : pin_rate_q.out_pin_value;
      RES_USE_FIXED <= tx_mode & ~power_cfg_q.power_resistor_sel;
      POWER_SET_RESISTOR <= power_cfg_q.power_resistor_code;
      FRONT_END_CFG <= power_cfg_q.front_end_cfg_bit;
      CLK_EN_FORCE <= wake_flag_q | deb_run_q;
      IRQ <= irq_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_PIN_VALUE: assert property (@(posedge SYS_CLK) disable iff (RST)
    !pin_rate_q.out_pin_source_sel |=> GENERAL_OUT_PIN == $past(pin_rate_q.out_pin_value))
    else $error("Output pin does not follow value bit");
  AST_PIN_RX_IND: assert property (@(posedge SYS_CLK) disable iff (RST)
    pin_rate_q.out_pin_source_sel && OP_MODE == tcs_pkg::MODE_RX |=> !GENERAL_OUT_PIN)
    else $error("Receive indicator not low in receive mode");
  AST_TX_PERIOD: assert property (@(posedge SYS_CLK) disable iff (RST)
    TX_BIT_TICK |-> $past(tx_cnt_q) == $past(tx_last) && $past(xdclk_tick))
    else $error("Tx bit tick at wrong count");
  AST_TX_ONLY: assert property (@(posedge SYS_CLK) disable iff (RST)
    TX_BIT_TICK |-> $past(OP_MODE) == tcs_pkg::MODE_TX)
    else $error("Tx bit tick outside transmit mode");
  AST_RES_FIXED: assert property (@(posedge SYS_CLK) disable iff (RST)
    (OP_MODE == tcs_pkg::MODE_FD) |=> !RES_USE_FIXED)
    else $error("Fixed resistor used in full duplex");
  AST_STATUS_CLEAR: assert property (@(posedge SYS_CLK) disable iff (RST)
    status_rd && !wake_rise && !irq_set && !ram_set |=> !wake_flag_q && !ram_flag_q && !irq_q &&
    key_state_q == $past(key_state_q))
    else $error("Status read did not clear flags");
  AST_CLK_HOLD: assert property (@(posedge SYS_CLK) disable iff (RST)
    wake_flag_q |=> CLK_EN_FORCE)
    else $error("Clock enable not held with wake flag");
  AST_KEY_IRQ: assert property (@(posedge SYS_CLK) disable iff (RST)
    deb_done |=> irq_q ##1 IRQ)
    else $error("Key event raised no interrupt");
  AST_KEY_INV: assert property (@(posedge SYS_CLK) disable iff (RST)
    deb_done |=> key_state_q != $past(key_s))
    else $error("Key status not inverse of pin");
  AST_OFF_IDLE: assert property (@(posedge SYS_CLK) disable iff (RST)
    off_to_idle |=> ram_flag_q)
    else $error("Supply flag not set after power up");
  AST_BIT7_ZERO: assert property (@(posedge SYS_CLK) disable iff (RST)
    !power_cfg_q.unused)
    else $error("Register 8 bit 7 stored a one");

endmodule // tcs_regs
